/* File: include/mlic_pkg.sv */
package mlic_pkg;

  localparam int PC_W  = 16;
  localparam int SP_W  = 16;
  localparam int N_SRC = 11;
  localparam int IDX_W = 4;
  localparam int OFF_W = 3;

  // word addresses in program memory
  localparam logic [PC_W-1:0] RESET_VEC       = 16'h0000;
  localparam logic [PC_W-1:0] OSC_FAIL_VECTOR = 16'h0002;
  localparam logic [PC_W-1:0] FIRST_PORT_BASE = 16'h0004;
  localparam logic [PC_W-1:0] RESET_PORT_BASE = 16'h0008;
  localparam logic [PC_W-1:0] DMA_BASE        = 16'h000C;
  localparam logic [PC_W-1:0] RTC_BASE        = 16'h0014;
  localparam logic [PC_W-1:0] TWO_WIRE_C_BASE = 16'h0018;
  localparam logic [PC_W-1:0] TIMER_C0_BASE   = 16'h001C;
  localparam logic [PC_W-1:0] TIMER_C1_BASE   = 16'h0028;
  localparam logic [PC_W-1:0] SPI_C_VECTOR    = 16'h0030;
  localparam logic [PC_W-1:0] USART_C0_BASE   = 16'h0032;
  localparam logic [PC_W-1:0] USART_C1_BASE   = 16'h0038;
  localparam logic [PC_W-1:0] CRYPTO_VECTOR   = 16'h003E;

  // source index of each request line
  localparam int SRC_FIRST_PORT = 0;
  localparam int SRC_RESET_PORT = 1;
  localparam int SRC_DMA        = 2;
  localparam int SRC_RTC        = 3;
  localparam int SRC_TWO_WIRE_C = 4;
  localparam int SRC_TIMER_C0   = 5;
  localparam int SRC_TIMER_C1   = 6;
  localparam int SRC_SPI_C      = 7;
  localparam int SRC_USART_C0   = 8;
  localparam int SRC_USART_C1   = 9;
  localparam int SRC_CRYPTO     = 10;

  // stack pointer reset value, boot start and stack steps
  localparam logic [SP_W-1:0] SP_RESET   = 16'h0FFF;
  localparam logic [PC_W-1:0] BOOT_START = 16'h2000;
  localparam logic [SP_W-1:0] STK_STEP   = 16'h0002;
  localparam logic [SP_W-1:0] STK_ONE    = 16'h0001;

  typedef enum logic [1:0] {LVL_OFF, LVL_LOW, LVL_MED, LVL_HIGH} mlic_lvl_t;
  typedef enum logic [1:0] {ST_RUN, ST_POP, ST_LOAD} mlic_state_t;

  function automatic logic [PC_W-1:0] base_of(input logic [IDX_W-1:0] idx);
    case (idx)
      4'h0:    return FIRST_PORT_BASE;
      4'h1:    return RESET_PORT_BASE;
      4'h2:    return DMA_BASE;
      4'h3:    return RTC_BASE;
      4'h4:    return TWO_WIRE_C_BASE;
      4'h5:    return TIMER_C0_BASE;
      4'h6:    return TIMER_C1_BASE;
      4'h7:    return SPI_C_VECTOR;
      4'h8:    return USART_C0_BASE;
      4'h9:    return USART_C1_BASE;
      default: return CRYPTO_VECTOR;
    endcase
  endfunction

  function automatic logic single_of(input logic [IDX_W-1:0] idx);
    return (idx == IDX_W'(SRC_SPI_C)) || (idx == IDX_W'(SRC_CRYPTO));
  endfunction

endpackage

/* File: include/mlic_arb_if.sv */
`timescale 1ns/1ps
interface mlic_arb_if #(parameter int N = 11);
  localparam int IW = $clog2(N);
  logic [N-1:0]  req;
  logic          rr_en;
  logic          take;
  logic [IW-1:0] take_idx;
  logic          gnt_vld;
  logic [IW-1:0] gnt_idx;
  modport ctrl (output req, rr_en, take, take_idx, input gnt_vld, gnt_idx);
  modport arb  (input req, rr_en, take, take_idx, output gnt_vld, gnt_idx);
endinterface

/* File: src/mlic_arb.sv */
`timescale 1ns/1ps
module mlic_arb
  import mlic_pkg::*;
#(
  parameter int N = N_SRC
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  mlic_arb_if.arb  bus
);
  localparam int IW = $clog2(N);

  logic [IW-1:0] last;

  // remember the last low source served
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      last <= IW'(N - 1);
    end else if (bus.take) begin
      last <= bus.take_idx;
    end
  end

  // fixed: lowest index; rotating: first after last served
  always_comb begin
    int j;
    j = 0;
    bus.gnt_vld = 1'b0;
    bus.gnt_idx = '0;
    if (bus.rr_en) begin
      for (int k = N; k >= 1; k--) begin
        j = (int'(last) + k) % N;
        if (bus.req[j]) begin
          bus.gnt_vld = 1'b1;
          bus.gnt_idx = IW'(j);
        end
      end
    end else begin
      for (int i = N - 1; i >= 0; i--) begin
        if (bus.req[i]) begin
          bus.gnt_vld = 1'b1;
          bus.gnt_idx = IW'(i);
        end
      end
    end
  end
endmodule

/* File: src/mlic_top.sv */
`timescale 1ns/1ps
module mlic_top
  import mlic_pkg::*;
#(
  parameter logic [SP_W-1:0] SP_INIT  = SP_RESET,
  parameter logic [PC_W-1:0] BOOT_VEC = BOOT_START
) (
  input  wire logic                   I_SYS_CLK,
  input  wire logic                   I_RESET_N,
  input  wire logic [N_SRC-1:0]       I_IRQ_REQ,
  input  wire logic [2*N_SRC-1:0]     I_IRQ_LVL,
  input  wire logic [OFF_W*N_SRC-1:0] I_IRQ_OFF,
  input  wire logic                   I_OSC_FAIL,
  input  wire logic [2:0]             I_LVL_EN,
  input  wire logic                   I_RR_EN,
  input  wire logic                   I_VEC_RELOC,
  input  wire logic                   I_GIE,
  input  wire logic                   I_BOUNDARY,
  input  wire logic                   I_PC_ADV,
  input  wire logic [PC_W-1:0]        I_PC_NEXT,
  input  wire logic                   I_CALL,
  input  wire logic [PC_W-1:0]        I_CALL_TARGET,
  input  wire logic                   I_RET,
  input  wire logic                   I_RETI,
  input  wire logic [PC_W-1:0]        I_STK_RDATA,
  input  wire logic                   I_SP_WE,
  input  wire logic [SP_W-1:0]        I_SP_WDATA,
  output logic      [PC_W-1:0]        O_PC,
  output logic      [SP_W-1:0]        O_SP,
  output logic                        O_STK_WE,
  output logic                        O_STK_RE,
  output logic      [SP_W-1:0]        O_STK_ADDR,
  output logic      [PC_W-1:0]        O_STK_WDATA,
  output logic                        O_ACK,
  output logic      [IDX_W-1:0]       O_ACK_SRC,
  output logic                        O_ACK_NMI,
  output logic      [PC_W-1:0]        O_VECTOR,
  output logic      [2:0]             O_LVL_ACTIVE,
  output logic                        O_NMI_ACTIVE,
  output logic      [2:0]             O_LVL_PEND,
  output logic                        O_BUSY
);

  mlic_state_t      state;
  logic             osc_s1;
  logic             osc_s2;
  logic             osc_s3;
  logic             nmi_pend;
  logic [2:0]       act;
  logic             nmi_act;
  logic [N_SRC-1:0] req_hi;
  logic [N_SRC-1:0] req_md;
  logic [N_SRC-1:0] req_lo;
  logic             any_hi;
  logic             any_md;
  logic             any_lo;
  logic             can_take;
  logic             take_nmi;
  logic             take_hi;
  logic             take_md;
  logic             take_lo;
  logic             take_irq;
  logic             flow_op;
  logic [IDX_W-1:0] sel_idx;
  mlic_lvl_t        sel_lvl;
  logic [PC_W-1:0]  next_vec;
  logic [PC_W-1:0]  raw_vec;
  logic [OFF_W-1:0] sel_off;
  logic [OFF_W-1:0] off_of [N_SRC];

  mlic_arb_if #(.N(N_SRC)) arb_bus ();

  mlic_arb #(
    .N (N_SRC)
  ) u_arb (
    .i_clk     (I_SYS_CLK),
    .i_reset_n (I_RESET_N),
    .bus       (arb_bus)
  );

  function automatic mlic_lvl_t lvl_of(input logic [2*N_SRC-1:0] v, input int i);
    return mlic_lvl_t'(v[2*i +: 2]);
  endfunction

  function automatic logic [IDX_W-1:0] first_set(input logic [N_SRC-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction

  // per-source level sorting
  for (genvar g = 0; g < N_SRC; g++) begin : g_src
    assign req_hi[g] = I_IRQ_REQ[g] & I_LVL_EN[2] & (lvl_of(I_IRQ_LVL, g) == LVL_HIGH);
    assign req_md[g] = I_IRQ_REQ[g] & I_LVL_EN[1] & (lvl_of(I_IRQ_LVL, g) == LVL_MED);
    assign req_lo[g] = I_IRQ_REQ[g] & I_LVL_EN[0] & (lvl_of(I_IRQ_LVL, g) == LVL_LOW);
    assign off_of[g] = I_IRQ_OFF[OFF_W*g +: OFF_W];
  end

  assign any_hi = |req_hi;
  assign any_md = |req_md;
  assign any_lo = arb_bus.gnt_vld;

  assign arb_bus.req      = req_lo;
  assign arb_bus.rr_en    = I_RR_EN;
  assign arb_bus.take     = take_irq & (sel_lvl == LVL_LOW);
  assign arb_bus.take_idx = sel_idx;

  // oscillator failure detector output is asynchronous
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= I_OSC_FAIL;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // non-maskable pending flag, a new failure wins over the take
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      nmi_pend <= 1'b0;
    end else if (osc_s2 & ~osc_s3) begin
      nmi_pend <= 1'b1;
    end else if (take_nmi) begin
      nmi_pend <= 1'b0;
    end
  end

  // entry permission and nesting
  assign flow_op  = I_CALL | I_RET | I_RETI | I_SP_WE;
  assign can_take = (state == ST_RUN) & I_BOUNDARY & ~flow_op;
  assign take_nmi = can_take & nmi_pend & ~nmi_act;
  assign take_hi  = any_hi & ~act[2] & ~nmi_act;
  assign take_md  = any_md & ~act[2] & ~act[1] & ~nmi_act;
  assign take_lo  = any_lo & ~(|act) & ~nmi_act;
  assign take_irq = can_take & I_GIE & ~take_nmi & (take_hi | take_md | take_lo);

  // source choice, highest level first
  always_comb begin
    sel_idx = '0;
    sel_lvl = LVL_OFF;
    if (take_hi) begin
      sel_idx = first_set(req_hi);
      sel_lvl = LVL_HIGH;
    end else if (take_md) begin
      sel_idx = first_set(req_md);
      sel_lvl = LVL_MED;
    end else if (take_lo) begin
      sel_idx = arb_bus.gnt_idx;
      sel_lvl = LVL_LOW;
    end
  end

  // vector word address
  always_comb begin
    sel_off = off_of[sel_idx];
    if (take_nmi) begin
      raw_vec = OSC_FAIL_VECTOR;
    end else if (single_of(sel_idx)) begin
      raw_vec = base_of(sel_idx);
    end else begin
      raw_vec = base_of(sel_idx) + PC_W'(sel_off);
    end
    if (I_VEC_RELOC) begin
      next_vec = raw_vec + BOOT_VEC;
    end else begin
      next_vec = raw_vec;
    end
  end

  // return sequence state
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= ST_RUN;
    end else begin
      case (state)
        ST_RUN: begin
          // a stack pointer write in the same cycle wins over the return
          if ((I_RET | I_RETI) & ~I_SP_WE) begin
            state <= ST_POP;
          end
        end
        ST_POP: begin
          state <= ST_LOAD;
        end
        ST_LOAD: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // program counter
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PC <= RESET_VEC;
    end else if (state == ST_LOAD) begin
      // stacked return word stands in the load cycle
      O_PC <= I_STK_RDATA;
    end else if (take_nmi | take_irq) begin
      O_PC <= next_vec;
    end else if (state == ST_RUN && I_CALL) begin
      O_PC <= I_CALL_TARGET;
    end else if (state == ST_RUN && I_PC_ADV && !(I_RET | I_RETI)) begin
      O_PC <= I_PC_NEXT;
    end
  end

  // stack pointer
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_SP <= SP_INIT;
    end else if (state == ST_RUN) begin
      if (I_SP_WE) begin
        O_SP <= I_SP_WDATA;
      end else if (I_RET | I_RETI) begin
        // return frees one word pair, entry or call takes one
        O_SP <= O_SP + STK_STEP;
      end else if (take_nmi | take_irq | I_CALL) begin
        O_SP <= O_SP - STK_STEP;
      end
    end
  end

  // stack memory strobes
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_STK_WE    <= 1'b0;
      O_STK_RE    <= 1'b0;
      O_STK_ADDR  <= '0;
      O_STK_WDATA <= '0;
    end else begin
      O_STK_WE <= 1'b0;
      O_STK_RE <= 1'b0;
      if (take_nmi | take_irq) begin
        O_STK_WE    <= 1'b1;
        O_STK_ADDR  <= O_SP - STK_ONE;
        O_STK_WDATA <= O_PC;
      end else if (state == ST_RUN && I_CALL && !I_SP_WE) begin
        O_STK_WE    <= 1'b1;
        O_STK_ADDR  <= O_SP - STK_ONE;
        O_STK_WDATA <= I_PC_NEXT;
      end else if (state == ST_RUN && (I_RET | I_RETI) && !I_SP_WE) begin
        O_STK_RE   <= 1'b1;
        O_STK_ADDR <= O_SP + STK_ONE;
      end
    end
  end

  // active levels, only a return from interrupt (I_RETI) drops the highest one, nmi first
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      act     <= 3'h0;
      nmi_act <= 1'b0;
    end else if (take_nmi) begin
      nmi_act <= 1'b1;
    end else if (take_irq) begin
      case (sel_lvl)
        LVL_HIGH: act[2] <= 1'b1;
        LVL_MED:  act[1] <= 1'b1;
        LVL_LOW:  act[0] <= 1'b1;
        default:  act    <= act;
      endcase
    end else if (state == ST_RUN && I_RETI && !I_SP_WE) begin
      if (nmi_act) begin
        nmi_act <= 1'b0;
      end else if (act[2]) begin
        act[2] <= 1'b0;
      end else if (act[1]) begin
        act[1] <= 1'b0;
      end else begin
        act[0] <= 1'b0;
      end
    end
  end

  // acknowledge to the peripheral and last vector taken
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_ACK     <= 1'b0;
      O_ACK_SRC <= '0;
      O_ACK_NMI <= 1'b0;
      O_VECTOR  <= RESET_VEC;
    end else begin
      O_ACK     <= take_irq;
      O_ACK_NMI <= take_nmi;
      if (take_irq) begin
        O_ACK_SRC <= sel_idx;
      end
      if (take_nmi | take_irq) begin
        O_VECTOR <= next_vec;
      end
    end
  end

  // level status
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_LVL_PEND <= 3'h0;
    end else begin
      O_LVL_PEND <= {any_hi, any_md, any_lo};
    end
  end

  assign O_LVL_ACTIVE = act;
  assign O_NMI_ACTIVE = nmi_act;
  assign O_BUSY       = (state != ST_RUN);

endmodule

/* File: sim/mlic_top_assertions.sv */
`timescale 1ns/1ps
module mlic_chk
  import mlic_pkg::*;
#(
  parameter logic [SP_W-1:0] SP_INIT  = SP_RESET,
  parameter logic [PC_W-1:0] BOOT_VEC = BOOT_START
) (
  input wire logic              I_SYS_CLK,
  input wire logic              I_RESET_N,
  input wire logic              I_CALL,
  input wire logic [PC_W-1:0]   I_CALL_TARGET,
  input wire logic [PC_W-1:0]   I_PC_NEXT,
  input wire logic              I_RET,
  input wire logic              I_RETI,
  input wire logic [PC_W-1:0]   I_STK_RDATA,
  input wire logic              I_SP_WE,
  input wire logic [SP_W-1:0]   I_SP_WDATA,
  input wire logic [PC_W-1:0]   O_PC,
  input wire logic [SP_W-1:0]   O_SP,
  input wire logic              O_STK_WE,
  input wire logic              O_STK_RE,
  input wire logic [SP_W-1:0]   O_STK_ADDR,
  input wire logic [PC_W-1:0]   O_STK_WDATA,
  input wire logic              O_ACK,
  input wire logic [IDX_W-1:0]  O_ACK_SRC,
  input wire logic              O_ACK_NMI,
  input wire logic [PC_W-1:0]   O_VECTOR,
  input wire logic [2:0]        O_LVL_ACTIVE,
  input wire logic              O_NMI_ACTIVE,
  input wire logic              O_BUSY
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  a_reset_state: assert property ($rose(I_RESET_N) |->
    O_PC == 16'h0 && O_SP == SP_INIT)
    else $error("reset state wrong");
  a_entry_push: assert property (O_ACK || O_ACK_NMI |-> O_STK_WE &&
    O_SP == $past(O_SP) - 16'h2 && O_STK_ADDR == $past(O_SP) - 16'h1 &&
    O_STK_WDATA == $past(O_PC))
    else $error("entry push wrong");
  a_ack_vector: assert property (O_ACK |-> O_PC == O_VECTOR && O_ACK_SRC < 4'hB &&
    O_PC >= 16'h0004)
    else $error("entry vector wrong");
  a_nmi_vector: assert property (O_ACK_NMI |-> O_NMI_ACTIVE && O_PC == O_VECTOR &&
    (O_PC == 16'h0002 || O_PC == 16'h0002 + BOOT_VEC))
    else $error("nmi vector wrong");
  a_ret_pop: assert property ((I_RET || I_RETI) && !I_SP_WE && !O_BUSY |=> O_STK_RE &&
    O_STK_ADDR == $past(O_SP) + 16'h1 && O_SP == $past(O_SP) + 16'h2
    ##2 O_PC == $past(I_STK_RDATA) && !O_BUSY)
    else $error("return sequence wrong");
  a_busy_hold: assert property (O_BUSY |=> !O_ACK && !O_ACK_NMI)
    else $error("entry while returning");
  a_level_rise: assert property (O_ACK |->
    (O_LVL_ACTIVE ^ $past(O_LVL_ACTIVE)) > $past(O_LVL_ACTIVE))
    else $error("entry at same or lower level");
  a_sp_write: assert property (I_SP_WE && !O_BUSY |=> O_SP == $past(I_SP_WDATA))
    else $error("stack pointer write lost");
  a_call_push: assert property (I_CALL && !I_SP_WE && !O_BUSY |=>
    O_PC == $past(I_CALL_TARGET) && O_STK_WE && O_STK_WDATA == $past(I_PC_NEXT))
    else $error("call push wrong");
endmodule

bind mlic_top mlic_chk #(
  .SP_INIT  (SP_INIT),
  .BOOT_VEC (BOOT_VEC)
) u_chk (
  .I_SYS_CLK     (I_SYS_CLK),
  .I_RESET_N     (I_RESET_N),
  .I_CALL        (I_CALL),
  .I_CALL_TARGET (I_CALL_TARGET),
  .I_PC_NEXT     (I_PC_NEXT),
  .I_RET         (I_RET),
  .I_RETI        (I_RETI),
  .I_STK_RDATA   (I_STK_RDATA),
  .I_SP_WE       (I_SP_WE),
  .I_SP_WDATA    (I_SP_WDATA),
  .O_PC          (O_PC),
  .O_SP          (O_SP),
  .O_STK_WE      (O_STK_WE),
  .O_STK_RE      (O_STK_RE),
  .O_STK_ADDR    (O_STK_ADDR),
  .O_STK_WDATA   (O_STK_WDATA),
  .O_ACK         (O_ACK),
  .O_ACK_SRC     (O_ACK_SRC),
  .O_ACK_NMI     (O_ACK_NMI),
  .O_VECTOR      (O_VECTOR),
  .O_LVL_ACTIVE  (O_LVL_ACTIVE),
  .O_NMI_ACTIVE  (O_NMI_ACTIVE),
  .O_BUSY        (O_BUSY)
);

/* File: sim/mlic_cpu_model.sv */
`timescale 1ns/1ps
module mlic_cpu_model
  import mlic_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_stk_we,
  input  wire logic            i_stk_re,
  input  wire logic [SP_W-1:0] i_stk_addr,
  input  wire logic [PC_W-1:0] i_stk_wdata,
  output logic      [PC_W-1:0] o_stk_rdata
);
  // data sram holding the return stack
  logic [PC_W-1:0] mem [2**SP_W];

  // read word valid only in the load cycle, scrambled otherwise
  always @(posedge i_clk) begin
    if (i_stk_we)
      mem[i_stk_addr] <= i_stk_wdata;
    if (i_stk_re)
      o_stk_rdata <= mem[i_stk_addr];
    else
      o_stk_rdata <= 16'hA5A5 ^ i_stk_addr;
  end
endmodule

/* File: sim/mlic_top_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module mlic_top_tb_top
  import mlic_pkg::*;
;
  logic                   clk, rst_n, osc, rr, reloc, gie, bnd, adv, call, ret, reti, spwe;
  logic [N_SRC-1:0]       req;
  logic [2*N_SRC-1:0]     lvl;
  logic [OFF_W*N_SRC-1:0] off;
  logic [2:0]             len, act, pend;
  logic [PC_W-1:0]        pcn, tgt, rdata, pc, swd, vec;
  logic [SP_W-1:0]        spwd, sp, sad;
  logic                   swe, sre, ack, anmi, nact, busy;
  logic [IDX_W-1:0]       asrc;
  int                     num_errors, n_tests;
  logic [PC_W-1:0]        base [N_SRC] = '{16'h0004, 16'h0008, 16'h000C, 16'h0014,
    16'h0018, 16'h001C, 16'h0028, 16'h0030, 16'h0032, 16'h0038, 16'h003E};

  mlic_top u_dut (
    .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_IRQ_REQ(req), .I_IRQ_LVL(lvl),
    .I_IRQ_OFF(off), .I_OSC_FAIL(osc), .I_LVL_EN(len), .I_RR_EN(rr),
    .I_VEC_RELOC(reloc), .I_GIE(gie), .I_BOUNDARY(bnd), .I_PC_ADV(adv),
    .I_PC_NEXT(pcn), .I_CALL(call), .I_CALL_TARGET(tgt), .I_RET(ret),
    .I_RETI(reti), .I_STK_RDATA(rdata), .I_SP_WE(spwe), .I_SP_WDATA(spwd),
    .O_PC(pc), .O_SP(sp), .O_STK_WE(swe), .O_STK_RE(sre), .O_STK_ADDR(sad),
    .O_STK_WDATA(swd), .O_ACK(ack), .O_ACK_SRC(asrc), .O_ACK_NMI(anmi),
    .O_VECTOR(vec), .O_LVL_ACTIVE(act), .O_NMI_ACTIVE(nact), .O_LVL_PEND(pend),
    .O_BUSY(busy)
  );
  mlic_cpu_model u_cpu (.i_clk(clk), .i_stk_we(swe), .i_stk_re(sre),
    .i_stk_addr(sad), .i_stk_wdata(swd), .o_stk_rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic nx(int n = 1);
    repeat (n) @(negedge clk);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic rst;
    rst_n = 1'b0;
    nx(8);
    rst_n = 1'b1;
    `CHK({pc, sp}, {16'h0000, SP_RESET})
    `CHK({busy, act, nact, vec}, 21'h0)
  endtask

  // wait for an entry strobe, bounded
  task automatic wt;
    for (int k = 0; k < 12; k++) begin
      nx();
      if (ack === 1'b1 || anmi === 1'b1)
        return;
    end
    num_errors++;
    stop_test();
  endtask

  task automatic ent(input int s, input logic [1:0] l, input logic [PC_W-1:0] v);
    logic [PC_W-1:0] p0;
    logic [SP_W-1:0] s0;
    p0 = pc;
    s0 = sp;
    lvl[2*s+:2] = l;
    req[s] = 1'b1;
    wt();
    req[s] = 1'b0;
    `CHK({ack, pc, asrc, vec}, {1'b1, v, IDX_W'(s), v})
    `CHK({swe, swd, sad, sp}, {1'b1, p0, s0 - 16'h1, s0 - 16'h2})
  endtask

  task automatic rt(input logic r, input logic [PC_W-1:0] e);
    ret = !r;
    reti = r;
    nx();
    ret = 1'b0;
    reti = 1'b0;
    `CHK({sre, busy}, 2'b11)
    nx(2);
    `CHK({busy, pc}, {1'b0, e})
  endtask

  task automatic nope(input int s, input logic [1:0] l);
    int c;
    c = 0;
    lvl[2*s+:2] = l;
    req[s] = 1'b1;
    repeat (4) begin
      nx();
      c += int'(ack === 1'b1);
    end
    `CHK(pend, len & (3'h1 << (l - 2'h1)))
    req[s] = 1'b0;
    `CHK(c, 0)
  endtask

  task automatic t_vec;
    for (int i = 0; i < N_SRC; i++) begin
      ent(i, LVL_LOW, base[i] + ((i == SRC_SPI_C || i == SRC_CRYPTO) ? 16'h0 :
        16'(off[3*i+:3])));
      rt(1'b1, 16'h0000);
    end
    reloc = 1'b1;
    ent(SRC_RTC, LVL_LOW, BOOT_START + 16'h0018);
    rt(1'b1, 16'h0000);
    reloc = 1'b0;
    $display("test vectors done");
  endtask

  task automatic t_nest;
    ent(0, LVL_LOW, 16'h0005);
    nope(1, LVL_LOW);
    ent(2, LVL_MED, 16'h000F);
    nope(3, LVL_MED);
    ent(5, LVL_HIGH, 16'h0022);
    `CHK(act, 3'b111)
    nope(6, LVL_HIGH);
    rt(1'b1, 16'h000F);
    `CHK(act, 3'b011)
    rt(1'b1, 16'h0005);
    `CHK(act, 3'b001)
    rt(1'b1, 16'h0000);
    $display("test nesting done");
  endtask

  task automatic t_nmi;
    gie = 1'b0;
    len = 3'h0;
    nope(4, LVL_HIGH);
    osc = 1'b1;
    wt();
    `CHK({anmi, nact, pc}, {2'b11, 16'h0002})
    rt(1'b1, 16'h0000);
    `CHK(nact, 1'b0)
    osc = 1'b0;
    gie = 1'b1;
    len = 3'h7;
    $display("test nmi done");
  endtask

  task automatic t_rr;
    logic [IDX_W-1:0] seq [6] = '{4'h4, 4'h9, 4'h4, 4'h4, 4'h4, 4'h4};
    rst();
    lvl[8+:2] = LVL_LOW;
    lvl[18+:2] = LVL_LOW;
    req[4] = 1'b1;
    req[9] = 1'b1;
    for (int k = 0; k < 6; k++) begin
      rr = (k < 3);
      wt();
      `CHK(asrc, seq[k])
      rt(1'b1, 16'h0000);
    end
    req = '0;
    $display("test low arbitration done");
  endtask

  task automatic t_call;
    logic [SP_W-1:0] s0;
    s0 = sp;
    pcn = 16'h0123;
    tgt = 16'h0456;
    call = 1'b1;
    nx();
    call = 1'b0;
    `CHK({pc, swe, swd, sp}, {16'h0456, 1'b1, 16'h0123, s0 - 16'h2})
    rt(1'b0, 16'h0123);
    spwd = 16'h0800;
    spwe = 1'b1;
    nx();
    spwe = 1'b0;
    `CHK(sp, 16'h0800)
    adv = 1'b1;
    pcn = 16'h0100;
    nx();
    adv = 1'b0;
    ent(0, LVL_LOW, 16'h0005);
    rt(1'b1, 16'h0100);
    $display("test call and stack pointer done");
  endtask

  initial begin
    {rst_n, osc, rr, reloc, adv, call, ret, reti, spwe} = '0;
    {gie, bnd} = 2'b11;
    len = 3'h7;
    req = '0;
    lvl = '0;
    {pcn, tgt, spwd} = '0;
    for (int i = 0; i < N_SRC; i++)
      off[3*i+:3] = 3'(i + 1);
    num_errors = 0;
    n_tests = 0;
    rst();
    t_vec();
    t_nest();
    t_nmi();
    t_rr();
    t_call();
    stop_test();
  end
endmodule
